// ### hdl/tmr_chan_pkg.sv
// Package: register map, field layout and constants of the timer channel block
package tmr_chan_pkg;
   // Printed offsets are register indexes; byte address is four times the index
   localparam logic [7:0] IDX_CHAN0_STATUS_CONTROL = 8'h15;
   localparam logic [7:0] IDX_CHAN0_VALUE_HIGH = 8'h16;
   localparam logic [7:0] IDX_CHAN0_VALUE_LOW = 8'h17;
   localparam logic [7:0] IDX_CHAN1_STATUS_CONTROL = 8'h18;
   localparam logic [7:0] IDX_CHAN1_VALUE_HIGH = 8'h19;
   localparam logic [7:0] IDX_CHAN1_VALUE_LOW = 8'h1a;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h1c;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h1d;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W = 12;
   localparam int NUM_CHAN = 2;
   // Status/control fields
   localparam int SC_FLAG = 7;
   localparam int SC_IRQ_EN = 6;
   localparam int SC_MODE_B = 5;
   localparam int SC_MODE_A = 4;
   localparam int SC_EDGE_B = 3;
   localparam int SC_EDGE_A = 2;
   localparam logic [7:0] SC_RESET = 8'h00;
   localparam logic [7:0] SC_WMASK = 8'h7c;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [1:0] EDGE_OFF = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   typedef enum logic [2:0] {
      MODE_PIN_OFF = 3'b000,
      MODE_CAPTURE = 3'b001,
      MODE_COMPARE = 3'b010,
      MODE_EDGE_PWM = 3'b011,
      MODE_CENTER_PWM = 3'b100
   } chan_mode_e;
endpackage : tmr_chan_pkg

// ### hdl/tmr_chan_unit.sv
// One capture/compare/PWM channel: mode decode, flag, value latching, pin logic
`timescale 1ns/10ps
`default_nettype none
module tmr_chan_unit
   import tmr_chan_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] counter_value,
   input wire logic center_align_select,
   input wire logic count_up,
   input wire logic sc_write,
   input wire logic [7:0] sc_wdata,
   input wire logic sc_read,
   input wire logic vh_write,
   input wire logic vl_write,
   input wire logic [7:0] v_wdata,
   input wire logic vh_read,
   input wire logic vl_read,
   input wire logic pin_in,
   output logic [7:0] sc_rdata,
   output logic [7:0] vh_rdata,
   output logic [7:0] vl_rdata,
   output logic event_pulse,
   output logic irq_request,
   output logic pin_out,
   output logic pin_oe
);
   logic flag;
   logic irq_en;
   logic mode_b;
   logic mode_a;
   logic [1:0] edge_sel;
   logic [15:0] value;
   logic [15:0] read_buf;
   logic read_locked;
   logic hi_read_done;
   logic lo_read_done;
   logic [7:0] wbuf_hi;
   logic [7:0] wbuf_lo;
   logic hi_written;
   logic lo_written;
   logic clear_armed;
   logic [2:0] pin_sync;
   logic pin_level;
   logic match;
   logic rise;
   logic fall;
   logic cap_event;
   logic next_pin_out;
   chan_mode_e mode;

   function automatic chan_mode_e decode_mode(input logic cas, input logic mb, input logic ma,
                                              input logic [1:0] els);
      if (els == EDGE_OFF) begin
         decode_mode = MODE_PIN_OFF;
      end else if (cas) begin
         decode_mode = MODE_CENTER_PWM;
      end else if (mb) begin
         decode_mode = MODE_EDGE_PWM;
      end else if (ma) begin
         decode_mode = MODE_COMPARE;
      end else begin
         decode_mode = MODE_CAPTURE;
      end
   endfunction : decode_mode

   // Software compare (code 00, compare mode) still sets the flag but leaves the pin
   wire logic soft_compare = !center_align_select && !mode_b && mode_a && edge_sel == EDGE_OFF;

   always_comb begin
      mode = decode_mode(center_align_select, mode_b, mode_a, edge_sel);
   end

   // Pin synchroniser: change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync <= 3'b000;
         pin_level <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[1:0], pin_in};
         if (pin_sync[1] == pin_sync[2]) begin
            pin_level <= pin_sync[2];
         end
      end
   end

   assign rise = pin_sync[1] == pin_sync[2] && pin_sync[2] && !pin_level;
   assign fall = pin_sync[1] == pin_sync[2] && !pin_sync[2] && pin_level;
   assign match = counter_value == value;
   // the pin must be stable before capture is entered; spurious edges left to software
   assign cap_event = mode == MODE_CAPTURE &&
                      ((edge_sel[0] && rise) || (edge_sel[1] && fall));

   always_comb begin
      next_pin_out = pin_out;
      unique case (mode)
         MODE_COMPARE: begin
            if (match) begin
               unique case (edge_sel)
                  EDGE_RISE: next_pin_out = !pin_out;
                  EDGE_FALL: next_pin_out = 1'b0;
                  EDGE_BOTH: next_pin_out = 1'b1;
                  default: next_pin_out = pin_out;
               endcase
            end
         end
         MODE_EDGE_PWM: begin
            // Period starts when the counter wraps to zero
            if (match) begin
               next_pin_out = edge_sel[0];
            end else if (counter_value == VALUE_RESET) begin
               next_pin_out = !edge_sel[0];
            end
         end
         MODE_CENTER_PWM: begin
            if (match) begin
               next_pin_out = count_up ? edge_sel[0] : !edge_sel[0];
            end
         end
         default: next_pin_out = pin_out;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= mode == MODE_COMPARE || mode == MODE_EDGE_PWM ||
                   mode == MODE_CENTER_PWM;
      end
   end

   // Event pulse: capture edge, or counter match in an output mode or in software compare
   wire logic chan_event = cap_event ||
                           ((mode != MODE_CAPTURE && mode != MODE_PIN_OFF || soft_compare) &&
                            match);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= chan_event;
      end
   end

   // Flag: read-while-set arms the clear; a new event disarms it and wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag <= 1'b0;
         clear_armed <= 1'b0;
      end else begin
         if (chan_event) begin
            flag <= 1'b1;
            clear_armed <= 1'b0;
         end else if (sc_write && !sc_wdata[SC_FLAG] && clear_armed) begin
            flag <= 1'b0;
            clear_armed <= 1'b0;
         end else if (sc_read && flag) begin
            clear_armed <= 1'b1;
         end
      end
   end

   // Control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en <= 1'b0;
         mode_b <= 1'b0;
         mode_a <= 1'b0;
         edge_sel <= EDGE_OFF;
      end else if (sc_write) begin
         irq_en <= sc_wdata[SC_IRQ_EN];
         mode_b <= sc_wdata[SC_MODE_B];
         mode_a <= sc_wdata[SC_MODE_A];
         edge_sel <= sc_wdata[SC_EDGE_B:SC_EDGE_A];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= (flag || chan_event) && irq_en;
      end
   end

   // Value register and write buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= VALUE_RESET;
         wbuf_hi <= 8'h00;
         wbuf_lo <= 8'h00;
         hi_written <= 1'b0;
         lo_written <= 1'b0;
      end else begin
         if (cap_event) begin
            value <= counter_value;
         end
         if (sc_write) begin
            hi_written <= 1'b0;
            lo_written <= 1'b0;
         end else if (mode != MODE_CAPTURE) begin
            if (vh_write) begin
               wbuf_hi <= v_wdata;
            end
            if (vl_write) begin
               wbuf_lo <= v_wdata;
            end
            if ((vh_write || hi_written) && (vl_write || lo_written)) begin
               value <= {vh_write ? v_wdata : wbuf_hi,
                         vl_write ? v_wdata : wbuf_lo};
               hi_written <= 1'b0;
               lo_written <= 1'b0;
            end else begin
               hi_written <= hi_written || vh_write;
               lo_written <= lo_written || vl_write;
            end
         end
      end
   end

   // Capture read latch: first byte read freezes both until the other is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_buf <= VALUE_RESET;
         read_locked <= 1'b0;
         hi_read_done <= 1'b0;
         lo_read_done <= 1'b0;
      end else if (sc_write || mode != MODE_CAPTURE) begin
         read_locked <= 1'b0;
         hi_read_done <= 1'b0;
         lo_read_done <= 1'b0;
      end else if (!read_locked && (vh_read || vl_read)) begin
         read_buf <= value;
         read_locked <= 1'b1;
         hi_read_done <= vh_read;
         lo_read_done <= vl_read;
      end else if (read_locked && ((vh_read && lo_read_done) || (vl_read && hi_read_done))) begin
         read_locked <= 1'b0;
         hi_read_done <= 1'b0;
         lo_read_done <= 1'b0;
      end
   end

   wire logic [15:0] read_view = read_locked ? read_buf : value;
   assign sc_rdata = {flag, irq_en, mode_b, mode_a, edge_sel, 2'b00};
   assign vh_rdata = read_view[15:8];
   assign vl_rdata = read_view[7:0];
endmodule : tmr_chan_unit
`default_nettype wire

// ### hdl/tmr_chan_top.sv
// Two timer channels with APB register slave and masked interrupt
`timescale 1ns/10ps
`default_nettype none
module tmr_chan_top
   import tmr_chan_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] counter_value,
   input wire logic center_align_select,
   input wire logic count_up,
   input wire logic [NUM_CHAN-1:0] chan_pin_in,
   output logic [NUM_CHAN-1:0] chan_pin_out,
   output logic [NUM_CHAN-1:0] chan_pin_oe,
   output logic [NUM_CHAN-1:0] chan_irq_request,
   output logic irq
);
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [NUM_CHAN-1:0] ev;
   logic [NUM_CHAN-1:0] pin_out_i;
   logic [NUM_CHAN-1:0] pin_oe_i;
   logic [NUM_CHAN-1:0] irq_i;
   logic [7:0] sc_rd [NUM_CHAN];
   logic [7:0] vh_rd [NUM_CHAN];
   logic [7:0] vl_rd [NUM_CHAN];
   logic [31:0] next_prdata;
   logic known;

   wire logic setup = psel && !penable;
   wire logic [7:0] idx = paddr[ADDR_LSB +: 8];
   // Misaligned accesses are refused, so they must not reach any register either
   wire logic aligned = paddr[ADDR_LSB-1:0] == '0;
   wire logic wr = setup && pwrite && aligned;
   wire logic rd = setup && !pwrite && aligned;

   function automatic logic [7:0] chan_idx(input int ch, input logic [7:0] base);
      chan_idx = base + 8'(3 * ch);
   endfunction : chan_idx

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : g_chan
         tmr_chan_unit u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .counter_value(counter_value),
            .center_align_select(center_align_select),
            .count_up(count_up),
            .sc_write(wr && idx == chan_idx(g, IDX_CHAN0_STATUS_CONTROL)),
            .sc_wdata(pwdata[7:0] & (SC_WMASK | 8'h80)),
            .sc_read(rd && idx == chan_idx(g, IDX_CHAN0_STATUS_CONTROL)),
            .vh_write(wr && idx == chan_idx(g, IDX_CHAN0_VALUE_HIGH)),
            .vl_write(wr && idx == chan_idx(g, IDX_CHAN0_VALUE_LOW)),
            .v_wdata(pwdata[7:0]),
            .vh_read(rd && idx == chan_idx(g, IDX_CHAN0_VALUE_HIGH)),
            .vl_read(rd && idx == chan_idx(g, IDX_CHAN0_VALUE_LOW)),
            .pin_in(chan_pin_in[g]),
            .sc_rdata(sc_rd[g]),
            .vh_rdata(vh_rd[g]),
            .vl_rdata(vl_rd[g]),
            .event_pulse(ev[g]),
            .irq_request(irq_i[g]),
            .pin_out(pin_out_i[g]),
            .pin_oe(pin_oe_i[g])
         );
      end
   endgenerate

   // Read mux; the capture latch sees the read at setup so data is taken pre-freeze
   always_comb begin
      next_prdata = RDATA_ZERO;
      known = 1'b0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (idx == chan_idx(c, IDX_CHAN0_STATUS_CONTROL)) begin
            next_prdata = {24'h00_0000, sc_rd[c]};
            known = 1'b1;
         end
         if (idx == chan_idx(c, IDX_CHAN0_VALUE_HIGH)) begin
            next_prdata = {24'h00_0000, vh_rd[c]};
            known = 1'b1;
         end
         if (idx == chan_idx(c, IDX_CHAN0_VALUE_LOW)) begin
            next_prdata = {24'h00_0000, vl_rd[c]};
            known = 1'b1;
         end
      end
      if (idx == IDX_IRQ_STATUS) begin
         next_prdata = {24'h00_0000, irq_status};
         known = 1'b1;
      end
      if (idx == IDX_IRQ_MASK) begin
         next_prdata = {24'h00_0000, irq_mask};
         known = 1'b1;
      end
      if (paddr[ADDR_LSB-1:0] != '0) begin
         known = 1'b0;
      end
   end

   // Answer one cycle after setup: pready high in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= RDATA_ZERO;
      end else begin
         pready <= setup;
         pslverr <= setup && !known;
         prdata <= rd && known ? next_prdata : RDATA_ZERO;
      end
   end

   // Sticky event status, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 8'h00;
         irq_mask <= 8'h00;
      end else begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            if (ev[c]) begin
               irq_status[c] <= 1'b1;
            end else if (wr && idx == IDX_IRQ_STATUS && pwdata[c]) begin
               irq_status[c] <= 1'b0;
            end
         end
         if (wr && idx == IDX_IRQ_MASK) begin
            irq_mask <= {6'b00_0000, pwdata[NUM_CHAN-1:0]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
         chan_pin_out <= '0;
         chan_pin_oe <= '0;
         chan_irq_request <= '0;
      end else begin
         irq <= |(irq_status & irq_mask);
         chan_pin_out <= pin_out_i;
         chan_pin_oe <= pin_oe_i;
         chan_irq_request <= irq_i;
      end
   end
endmodule : tmr_chan_top
`default_nettype wire

// ### verification/tmr_chan_assertions.sv
// Concurrent checks on the timer channel block ports, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module tmr_chan_assertions
   import tmr_chan_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_CHAN-1:0] chan_pin_oe,
   input wire logic [NUM_CHAN-1:0] chan_irq_request,
   input wire logic irq
);
   localparam logic [ADDR_W-1:0] SC0_ADDR = {2'b00, IDX_CHAN0_STATUS_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] SC1_ADDR = {2'b00, IDX_CHAN1_STATUS_CONTROL, 2'b00};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence sc_write_s(logic [ADDR_W-1:0] a);
      setup_s ##0 (pwrite && paddr == a);
   endsequence
   setup_answer_a: assert property (setup_s |=> pready)
      else $error("setup not answered next cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held past one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_data_a: assert property (pslverr |-> prdata == RDATA_ZERO)
      else $error("refused access returns data");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   unmapped_err_a: assert property (setup_s ##0 (paddr == 12'h0fc) |=> pslverr)
      else $error("unmapped access not refused");
   reserved_zero_a:
      assert property (setup_s ##0 (!pwrite && paddr == SC1_ADDR) |=> prdata[1:0] == 2'b00)
      else $error("reserved control bits read nonzero");
   release_pin_a:
      assert property (sc_write_s(SC1_ADDR) ##0 (pwdata[3:2] == EDGE_OFF)
         |-> ##[1:3] !chan_pin_oe[1])
      else $error("pin not released on edge code zero");
   drive_pin_a:
      assert property (sc_write_s(SC0_ADDR) ##0 (pwdata[5:4] == 2'b01 && pwdata[3:2] != EDGE_OFF)
         |-> ##[1:3] chan_pin_oe[0])
      else $error("compare output not driven");
   reset_quiet_a: assert property ($rose(presetn) |-> chan_irq_request == '0 && !irq && !pready)
      else $error("outputs active after reset");
endmodule : tmr_chan_assertions
bind tmr_chan_top tmr_chan_assertions u_tmr_chan_assertions (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .chan_pin_oe(chan_pin_oe),
   .chan_irq_request(chan_irq_request),
   .irq(irq)
);
`default_nettype wire

// ### verification/tmr_pin_model.sv
// Far side of the channel pins: wire level from the channel or an external source
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_model
   import tmr_chan_pkg::*;
(
   input wire logic [NUM_CHAN-1:0] pin_out,
   input wire logic [NUM_CHAN-1:0] pin_oe,
   input wire logic [NUM_CHAN-1:0] ext_level,
   output logic [NUM_CHAN-1:0] pin_in
);
   // Channel wins while it drives, so compare outputs loop back to the input
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule : tmr_pin_model
`default_nettype wire

// ### verification/tb_timer_channel_capture_compare_pwm.sv
// Self-checking bench: registers, compare, capture, PWM and interrupts
`timescale 1ns/10ps
`default_nettype none
module tb_timer_channel_capture_compare_pwm;
   import tmr_chan_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic center_align_select, count_up, irq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] counter_value;
   logic [NUM_CHAN-1:0] pin_in, pin_out, pin_oe, irq_req, ext_level;
   logic [1:0] cmp_code [4] = '{EDGE_RISE, EDGE_RISE, EDGE_FALL, EDGE_BOTH};
   logic cmp_pin [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   tmr_chan_top u_tmr_chan_top (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .counter_value(counter_value),
      .center_align_select(center_align_select),
      .count_up(count_up),
      .chan_pin_in(pin_in),
      .chan_pin_out(pin_out),
      .chan_pin_oe(pin_oe),
      .chan_irq_request(irq_req),
      .irq(irq)
   );
   tmr_pin_model u_tmr_pin_model (
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .ext_level(ext_level),
      .pin_in(pin_in)
   );
   task automatic stop_test();
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       input logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      check(32'(pslverr), 32'(err));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d, 1'b0);
   endtask : wr
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0000_0000, 1'b0);
      check(rd, exp);
   endtask : rdchk
   // Counter parks at a value that matches no programmed compare value
   task automatic hit(input logic [15:0] v, input logic up);
      @(posedge pclk);
      counter_value <= v;
      count_up <= up;
      @(posedge pclk);
      counter_value <= 16'h0100;
      repeat (5) @(posedge pclk);
   endtask : hit
   task automatic pin_edge(input logic lvl, input logic [15:0] c);
      @(posedge pclk);
      counter_value <= c;
      ext_level[0] <= lvl;
      repeat (8) @(posedge pclk);
   endtask : pin_edge
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      counter_value = 16'h0100;
      center_align_select = 1'b0;
      count_up = 1'b1;
      ext_level = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) rdchk(IDX_CHAN0_STATUS_CONTROL + 8'(i), 32'h0000_0000);
      xfer(1'b0, 8'h3f, 32'h0000_0000, 1'b1);
      check(rd, 32'h0000_0000);
      xfer(1'b1, 8'h3f, 32'h0000_00ff, 1'b1);
      wr(IDX_CHAN1_STATUS_CONTROL, 32'h0000_00ff);
      rdchk(IDX_CHAN1_STATUS_CONTROL, 32'h0000_007c);
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_0014);
      wr(IDX_CHAN0_VALUE_LOW, 32'h0000_0034);
      rdchk(IDX_CHAN0_VALUE_LOW, 32'h0000_0000);
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_0014);
      wr(IDX_CHAN0_VALUE_HIGH, 32'h0000_0012);
      rdchk(IDX_CHAN0_VALUE_HIGH, 32'h0000_0000);
      wr(IDX_CHAN0_VALUE_LOW, 32'h0000_0034);
      rdchk(IDX_CHAN0_VALUE_HIGH, 32'h0000_0012);
      rdchk(IDX_CHAN0_VALUE_LOW, 32'h0000_0034);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_CHAN0_STATUS_CONTROL, {28'h000_0000, cmp_code[i], 2'b00} | 32'h0000_0010);
         hit(16'h1234, 1'b1);
         check(32'(pin_out[0]), 32'(cmp_pin[i]));
         rdchk(IDX_CHAN0_STATUS_CONTROL, {24'h00_0000, 4'h9, cmp_code[i], 2'b00});
      end
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_00dc);
      repeat (3) @(posedge pclk);
      check(32'(irq_req[0]), 32'h0000_0001);
      rdchk(IDX_CHAN0_STATUS_CONTROL, 32'h0000_00dc);
      hit(16'h1234, 1'b1);
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_005c);
      rdchk(IDX_CHAN0_STATUS_CONTROL, 32'h0000_00dc);
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_005c);
      rdchk(IDX_CHAN0_STATUS_CONTROL, 32'h0000_005c);
      check(32'(irq_req[0]), 32'h0000_0000);
      rdchk(IDX_IRQ_STATUS, 32'h0000_0001);
      check(32'(irq), 32'h0000_0000);
      wr(IDX_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0000_0001);
      wr(IDX_IRQ_STATUS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0000_0000);
      rdchk(IDX_IRQ_STATUS, 32'h0000_0000);
      // Pin stays quiet well beyond two cycles before each capture setup
      for (int k = 1; k < 4; k++) begin
         wr(IDX_CHAN0_STATUS_CONTROL, 32'(k << 2));
         xfer(1'b0, IDX_CHAN0_STATUS_CONTROL, 32'h0000_0000, 1'b0);
         wr(IDX_CHAN0_STATUS_CONTROL, 32'(k << 2));
         pin_edge(1'b1, 16'h0a0b);
         pin_edge(1'b0, 16'h0c0d);
         rdchk(IDX_CHAN0_VALUE_HIGH, (k == 1) ? 32'h0000_000a : 32'h0000_000c);
         rdchk(IDX_CHAN0_VALUE_LOW, (k == 1) ? 32'h0000_000b : 32'h0000_000d);
         rdchk(IDX_CHAN0_STATUS_CONTROL, 32'(8'h80 | (k << 2)));
      end
      rdchk(IDX_CHAN0_VALUE_HIGH, 32'h0000_000c);
      pin_edge(1'b1, 16'h0e0f);
      rdchk(IDX_CHAN0_VALUE_LOW, 32'h0000_000d);
      rdchk(IDX_CHAN0_VALUE_HIGH, 32'h0000_000e);
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_000c);
      pin_edge(1'b0, 16'h1a1b);
      rdchk(IDX_CHAN0_VALUE_LOW, 32'h0000_001b);
      wr(IDX_CHAN1_VALUE_LOW, 32'h0000_0040);
      wr(IDX_CHAN1_VALUE_HIGH, 32'h0000_0000);
      rdchk(IDX_CHAN1_VALUE_LOW, 32'h0000_0040);
      for (int m = 0; m < 2; m++) begin
         for (int k = 1; k < 4; k++) begin
            center_align_select <= 1'(m);
            wr(IDX_CHAN1_STATUS_CONTROL, 32'(((m == 0) ? 8'h20 : 8'h00) | (k << 2)));
            hit((m == 0) ? 16'h0000 : 16'h0040, 1'(m == 0));
            check(32'(pin_out[1]), 32'(k % 2 == 0));
            hit(16'h0040, 1'b1);
            check(32'(pin_out[1]), 32'(k % 2));
            check(32'(pin_oe[1]), 32'h0000_0001);
         end
      end
      center_align_select <= 1'b0;
      wr(IDX_CHAN1_STATUS_CONTROL, 32'h0000_0020);
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_0010);
      repeat (3) @(posedge pclk);
      check(32'(pin_oe), 32'h0000_0000);
      // Software compare: match sets the flag while the pin stays released
      rdchk(IDX_CHAN0_STATUS_CONTROL, 32'h0000_0090);
      wr(IDX_CHAN0_STATUS_CONTROL, 32'h0000_0010);
      wr(IDX_CHAN0_VALUE_HIGH, 32'h0000_0012);
      wr(IDX_CHAN0_VALUE_LOW, 32'h0000_0034);
      rdchk(IDX_CHAN0_STATUS_CONTROL, 32'h0000_0010);
      hit(16'h1234, 1'b1);
      check(32'(pin_oe[0]), 32'h0000_0000);
      rdchk(IDX_CHAN0_STATUS_CONTROL, 32'h0000_0090);
      stop_test();
   end
endmodule : tb_timer_channel_capture_compare_pwm
`default_nettype wire
